// ### hw/t1_ctrl_defs.vh
// Purpose: constants for the framer error-insertion and reset control bank
// Assumes: byte-wide parallel register port, offsets are byte addresses
// Notes: included by both design files
`ifndef T1_CTRL_DEFS_VH
`define T1_CTRL_DEFS_VH
`define ADDR_IDLE_MSG 8'h18
`define ADDR_ERR_INJ 8'h19
`define ADDR_RST_CTRL 8'h1a
`define ADDR_IRQ_MASK0 8'h1b
`define INJ_BPV 7
`define INJ_CRC 6
`define INJ_FT 5
`define INJ_FS 4
`define INJ_LOSS 3
`define INJ_PAY 2
`define INJ_ALARM_SEL 0
`define RC_SWRST 7
`define RC_SUSPEND 6
`define RC_ACK 5
`define RC_CNT_CLEAR 4
`define RC_SAMPLE 3
`define RC_OSC_SEL 2
`define RST_IDLE_MSG 8'h00
`define RST_ERR_INJ 8'h00
`define RST_RST_CTRL 8'h00
`define RST_IRQ_MASK0 8'h00
`define RC_WR_MASK 8'h7c
`define INJ_WR_MASK 8'hfd
`define SWRST_CYCLES 3'h4
`define SEF_WINDOW 6
`endif

// ### hw/err_counter.v
// Purpose: one 8-bit error counter with clear and one-second sampling
// Assumes: events are one-cycle pulses
// Notes: readable copy only moves on tick while sampling
`include "t1_ctrl_defs.vh"
module err_counter #(
    parameter WIDTH = 8
) (
    input wire clk_i, // framer clock
    input wire rst_n_i, // synchronised reset
    input wire soft_rst_i, // software reset pulse
    input wire event_i, // error event
    input wire clear_i, // hold at zero
    input wire sample_i, // one-second sample mode
    input wire tick_i, // one-second tick
    output reg [WIDTH-1:0] count_o // readable count
);
reg [WIDTH-1:0] acc_reg;
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        acc_reg <= {WIDTH{1'b0}};
        count_o <= {WIDTH{1'b0}};
    end else if (soft_rst_i || clear_i) begin
        acc_reg <= {WIDTH{1'b0}};
        count_o <= {WIDTH{1'b0}};
    end else if (sample_i) begin
        if (tick_i) begin
            count_o <= acc_reg + {{(WIDTH-1){1'b0}}, event_i};
            acc_reg <= {WIDTH{1'b0}};
        end else begin
            acc_reg <= acc_reg + {{(WIDTH-1){1'b0}}, event_i};
        end
    end else begin
        acc_reg <= {WIDTH{1'b0}};
        count_o <= count_o + {{(WIDTH-1){1'b0}}, event_i};
    end
end
endmodule // err_counter

// ### hw/t1_error_insert_reset_irq_ctrl.v
// Purpose: control bank for idle message, error insertion, reset, interrupts
// Assumes: synchronous byte port; transmit path marks its bit slots
// Notes: irq and alarm are open-drain/level; tri-state left to the pad
`include "t1_ctrl_defs.vh"
module t1_error_insert_reset_irq_ctrl #(
    parameter NCNT = 6
) (
    input wire clk_i, // framer clock, 10 MHz
    input wire resetn_i, // async reset, active low
    input wire cs_i, // register select
    input wire wr_i, // write strobe
    input wire rd_i, // read strobe
    input wire [7:0] addr_i, // register address
    input wire [7:0] wdata_i, // write data
    output reg [7:0] rdata_o, // read data
    input wire chan_msg_sel_i, // current channel selected for message
    input wire chan_slot_i, // payload bit slot of a channel
    input wire [2:0] chan_bit_i, // bit index in channel
    input wire tx_data_i, // transmit bit from framer
    input wire ft_slot_i, // terminal framing bit slot
    input wire fs_slot_i, // signalling framing bit slot
    input wire crc_slot_i, // crc-6 bit slot
    input wire esf_mode_i, // extended superframe active
    input wire pulse_slot_i, // mark bit slot for bpv
    output reg tx_data_o, // transmit bit after insertion
    output reg bpv_force_o, // force violation on this mark
    output reg line_zero_o, // suppress all pulses
    input wire los_i, // loss of signal state
    input wire lof_i, // loss of frame state
    output reg alarm_pin_o, // alarm output level
    output reg osc_ext_sel_o, // oscillator pin as logic input
    input wire frame_sync_i, // terminal frame sync state
    input wire mframe_sync_i, // multiframe sync state
    input wire ais_i, // all-ones alarm state
    input wire fbit_err_i, // framing bit error pulse
    input wire tx_slip_i, // transmit slip pulse
    input wire rx_slip_i, // receive slip pulse
    output reg irq_n_o, // interrupt pin output, low active
    output reg irq_oe_o, // interrupt pin drive enable
    input wire [NCNT-1:0] cnt_event_i, // counter error events
    input wire tick_1s_i, // one-second timer tick
    output reg [8*NCNT-1:0] counts_o // error counter values
);
// ------------------------------------------------------------
// reset synchroniser and software reset
// ------------------------------------------------------------
// release is synchronous so no flop leaves reset on a runt edge
reg rst_meta_reg;
reg rst_n;
always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rst_meta_reg <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_n <= rst_meta_reg;
    end
end

function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
        wr_hit = (a == target);
    end
endfunction

wire wr_en = cs_i && wr_i;
reg [2:0] swrst_cnt_reg;
wire swrst_start = wr_en && wr_hit(addr_i, `ADDR_RST_CTRL) &&
    wdata_i[`RC_SWRST];
wire soft_rst = (swrst_cnt_reg != 3'h0);
// reads back on bit 7 while it runs; a new request meanwhile is
// dropped rather than restarting the count
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)
        swrst_cnt_reg <= 3'h0;
    else if (swrst_start && !soft_rst)
        swrst_cnt_reg <= `SWRST_CYCLES;
    else if (soft_rst)
        swrst_cnt_reg <= swrst_cnt_reg - 3'h1;
end

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [7:0] idle_msg_reg;
reg [7:0] err_inj_reg;
reg [7:0] rst_ctrl_reg;
reg [7:0] irq_mask0_reg;
reg [7:0] irq_status_reg;
wire ack = wr_en && wr_hit(addr_i, `ADDR_RST_CTRL) && wdata_i[`RC_ACK];
// writes landing during the internal reset are dropped
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        idle_msg_reg <= `RST_IDLE_MSG;
        err_inj_reg <= `RST_ERR_INJ;
        rst_ctrl_reg <= `RST_RST_CTRL;
        irq_mask0_reg <= `RST_IRQ_MASK0;
    end else if (soft_rst) begin
        idle_msg_reg <= `RST_IDLE_MSG;
        err_inj_reg <= `RST_ERR_INJ;
        rst_ctrl_reg <= `RST_RST_CTRL;
        irq_mask0_reg <= `RST_IRQ_MASK0;
    end else if (wr_en) begin
        if (wr_hit(addr_i, `ADDR_IDLE_MSG))
            idle_msg_reg <= wdata_i;
        if (wr_hit(addr_i, `ADDR_ERR_INJ))
            err_inj_reg <= wdata_i & `INJ_WR_MASK;
        // swrst shows while active; ack never stored, reserved kept 0
        if (wr_hit(addr_i, `ADDR_RST_CTRL))
            rst_ctrl_reg <= wdata_i & `RC_WR_MASK & 8'hdf;
        if (wr_hit(addr_i, `ADDR_IRQ_MASK0))
            irq_mask0_reg <= wdata_i;
    end
end

// ------------------------------------------------------------
// injection edge detect and pending flags
// ------------------------------------------------------------
reg [7:0] inj_prev_reg;
reg [3:0] pend_reg; // bpv crc ft fs
reg pend_pay_reg;
wire [7:0] rise = err_inj_reg & ~inj_prev_reg;
// a pending injection waits for its slot; crc waits on extended
// superframe, Fs on D4, so a wrong mode leaves it pending
wire use_bpv = pend_reg[3] && pulse_slot_i;
wire use_crc = pend_reg[2] && crc_slot_i && esf_mode_i;
wire use_ft = pend_reg[1] && ft_slot_i;
wire use_fs = pend_reg[0] && fs_slot_i && !esf_mode_i;
wire use_pay = pend_pay_reg && chan_slot_i && !chan_msg_sel_i;
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        inj_prev_reg <= 8'h00;
        pend_reg <= 4'h0;
        pend_pay_reg <= 1'b0;
    end else if (soft_rst) begin
        inj_prev_reg <= 8'h00;
        pend_reg <= 4'h0;
        pend_pay_reg <= 1'b0;
    end else begin
        inj_prev_reg <= err_inj_reg;
        // set wins over consumption in the same cycle
        pend_reg[3] <= rise[`INJ_BPV] | (pend_reg[3] & ~use_bpv);
        pend_reg[2] <= rise[`INJ_CRC] | (pend_reg[2] & ~use_crc);
        pend_reg[1] <= rise[`INJ_FT] | (pend_reg[1] & ~use_ft);
        pend_reg[0] <= rise[`INJ_FS] | (pend_reg[0] & ~use_fs);
        pend_pay_reg <= rise[`INJ_PAY] | (pend_pay_reg & ~use_pay);
    end
end

// ------------------------------------------------------------
// transmit data path
// ------------------------------------------------------------
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        tx_data_o <= 1'b0;
        bpv_force_o <= 1'b0;
        line_zero_o <= 1'b0;
    end else begin
        // forced loss overrides message and injection; pending ones
        // still drain while quiet, so nothing fires after it ends
        line_zero_o <= err_inj_reg[`INJ_LOSS];
        bpv_force_o <= use_bpv && !err_inj_reg[`INJ_LOSS];
        if (err_inj_reg[`INJ_LOSS])
            tx_data_o <= 1'b0;
        else if (chan_slot_i && chan_msg_sel_i)
            tx_data_o <= idle_msg_reg[chan_bit_i];
        else if (use_crc || use_ft || use_fs || use_pay)
            tx_data_o <= ~tx_data_i;
        else
            tx_data_o <= tx_data_i;
    end
end

// ------------------------------------------------------------
// alarm pin, oscillator select
// ------------------------------------------------------------
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        alarm_pin_o <= 1'b0;
        osc_ext_sel_o <= 1'b0;
    end else begin
        // one cycle of latency, kept so the pin comes from a flop
        alarm_pin_o <= err_inj_reg[`INJ_ALARM_SEL] ? los_i :
            (los_i | lof_i);
        osc_ext_sel_o <= rst_ctrl_reg[`RC_OSC_SEL];
    end
end

// ------------------------------------------------------------
// interrupt sources and status
// ------------------------------------------------------------
reg fsync_d_reg, msync_d_reg, ais_d_reg, los_d_reg;
reg [2:0] sef_win_reg; // framing slots since the last error
reg sef_seen_reg;
reg [7:0] ev;
wire suspend = rst_ctrl_reg[`RC_SUSPEND];
// change detectors reset low; a source high out of reset shows one
// change, harmless because every mask resets to zero
always @* begin
    ev = 8'h00;
    ev[7] = frame_sync_i ^ fsync_d_reg;
    ev[6] = mframe_sync_i ^ msync_d_reg;
    ev[4] = ais_i ^ ais_d_reg;
    ev[3] = los_i ^ los_d_reg;
    ev[2] = ft_slot_i && fbit_err_i && sef_seen_reg &&
        (sef_win_reg < `SEF_WINDOW - 1);
    ev[1] = tx_slip_i;
    ev[0] = rx_slip_i;
end
// sef window counts framing bit slots since the last framing error
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        fsync_d_reg <= 1'b0;
        msync_d_reg <= 1'b0;
        ais_d_reg <= 1'b0;
        los_d_reg <= 1'b0;
        sef_win_reg <= 3'h0;
        sef_seen_reg <= 1'b0;
        irq_status_reg <= 8'h00;
    end else begin
        fsync_d_reg <= frame_sync_i;
        msync_d_reg <= mframe_sync_i;
        ais_d_reg <= ais_i;
        los_d_reg <= los_i;
        if (ft_slot_i) begin
            // a lone error only arms the window
            if (fbit_err_i) begin
                sef_seen_reg <= 1'b1;
                sef_win_reg <= 3'h0;
            end else if (sef_win_reg < `SEF_WINDOW - 1) begin
                sef_win_reg <= sef_win_reg + 3'h1;
            end else begin
                sef_seen_reg <= 1'b0;
            end
        end
        // events set over acknowledge; suspended events are dropped
        if (soft_rst)
            irq_status_reg <= 8'h00;
        else if (suspend)
            irq_status_reg <= ack ? 8'h00 : irq_status_reg;
        else
            irq_status_reg <= (ack ? 8'h00 : irq_status_reg) |
                (ev & irq_mask0_reg);
    end
end
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        irq_n_o <= 1'b1;
        irq_oe_o <= 1'b0;
    end else begin
        // only ever pulls low; the pad floats it when drive is off
        irq_n_o <= 1'b0;
        irq_oe_o <= !suspend && !ack &&
            ((irq_status_reg & irq_mask0_reg) != 8'h00);
    end
end

// ------------------------------------------------------------
// error counters
// ------------------------------------------------------------
wire [8*NCNT-1:0] cnt_w;
genvar gi;
generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
        err_counter #(.WIDTH(8)) u_cnt (
            .clk_i(clk_i),
            .rst_n_i(rst_n),
            .soft_rst_i(soft_rst),
            .event_i(cnt_event_i[gi]),
            .clear_i(rst_ctrl_reg[`RC_CNT_CLEAR]),
            .sample_i(rst_ctrl_reg[`RC_SAMPLE]),
            .tick_i(tick_1s_i),
            .count_o(cnt_w[8*gi+7:8*gi])
        );
    end
endgenerate
// extra stage keeps the port straight from a flop, one cycle late
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)
        counts_o <= {8*NCNT{1'b0}};
    else
        counts_o <= cnt_w;
end

// ------------------------------------------------------------
// read port
// ------------------------------------------------------------
always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
        rdata_o <= 8'h00;
    end else if (cs_i && rd_i) begin
        // status words live elsewhere; unmapped reads return zero
        case (addr_i)
            `ADDR_IDLE_MSG: rdata_o <= idle_msg_reg;
            `ADDR_ERR_INJ: rdata_o <= err_inj_reg;
            `ADDR_RST_CTRL: rdata_o <= rst_ctrl_reg |
                {soft_rst, 7'h00};
            `ADDR_IRQ_MASK0: rdata_o <= irq_mask0_reg;
            default: rdata_o <= 8'h00;
        endcase
    end
end
endmodule // t1_error_insert_reset_irq_ctrl

// ### sim/t1_ctrl_asserts.sv
// Purpose: port checks for the framer control bank
// Assumes: one framer clock domain, resetn_i as the disable
// Notes: register effects are keyed off the writes seen at the port
`include "t1_ctrl_defs.vh"
module t1_ctrl_asserts (
    input wire clk_i, // framer clock
    input wire resetn_i, // async reset
    input wire cs_i, // select
    input wire wr_i, // write
    input wire rd_i, // read
    input wire [7:0] addr_i, // address
    input wire [7:0] wdata_i, // write data
    input wire [7:0] rdata_o, // read data
    input wire pulse_slot_i, // mark slot
    input wire bpv_force_o, // violation pulse
    input wire line_zero_o, // no pulses
    input wire los_i, // signal loss
    input wire lof_i, // frame loss
    input wire alarm_pin_o, // alarm level
    input wire irq_n_o, // irq level
    input wire irq_oe_o // irq drive
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------
    // writes seen at the port
    // ----------------------------------------
    sequence s_loss_wr;
        cs_i && wr_i && addr_i == `ADDR_ERR_INJ && wdata_i[`INJ_LOSS];
    endsequence
    sequence s_susp_wr;
        cs_i && wr_i && addr_i == `ADDR_RST_CTRL && wdata_i[7:5] == 3'h2;
    endsequence
    // read two cycles after write, as the bench spaces its strobes
    sequence s_mask_rw;
        cs_i && wr_i && addr_i == `ADDR_IRQ_MASK0 ##2
        cs_i && rd_i && addr_i == `ADDR_IRQ_MASK0;
    endsequence
    a_alarm_los: assert property (los_i |=> alarm_pin_o)
        else $error("alarm low during signal loss");
    a_alarm_clear: assert property (!los_i && !lof_i |=> !alarm_pin_o)
        else $error("alarm high with no loss");
    a_bpv_slot: assert property (bpv_force_o |-> $past(pulse_slot_i))
        else $error("violation outside a mark slot");
    a_bpv_single: assert property (bpv_force_o |=> !bpv_force_o)
        else $error("violation pulse longer than one cycle");
    a_rd_unmapped: assert property (cs_i && rd_i && addr_i < 8'h18 ##1 !rd_i
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_mask_readback: assert property (s_mask_rw ##1 !rd_i
        |=> rdata_o == $past(wdata_i, 4))
        else $error("mask word readback differs");
    a_suspend_quiet: assert property (s_susp_wr ##1 !(cs_i && wr_i)
        |=> !irq_oe_o)
        else $error("irq driven while suspended");
    a_irq_level: assert property (irq_oe_o |-> !irq_n_o)
        else $error("irq driven high");
    a_loss_force: assert property (s_loss_wr ##1 !(cs_i && wr_i)
        |=> line_zero_o)
        else $error("forced loss not applied");
endmodule // t1_ctrl_asserts
bind t1_error_insert_reset_irq_ctrl t1_ctrl_asserts u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .cs_i(cs_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .pulse_slot_i(pulse_slot_i), .bpv_force_o(bpv_force_o),
    .line_zero_o(line_zero_o), .los_i(los_i), .lof_i(lof_i),
    .alarm_pin_o(alarm_pin_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o)
);

// ### sim/t1_error_insert_reset_irq_ctrl_bench.sv
// Purpose: self-checking bench for the framer control bank
// Assumes: inputs change 10 ns after the rising edge
// Notes: slots held steady so one injection shows as one flipped bit, or as one bpv_o pulse for bpv
`include "t1_ctrl_defs.vh"
module t1_error_insert_reset_irq_ctrl_bench;
timeunit 1ns;
timeprecision 1ns;
logic clk_i = '0, resetn_i = '0, cs = '0, wr = '0, rd = '0;
logic [7:0] addr = '0, wdat = '0, rd_v;
logic msel = '0, cslot = '0, tx_i = '0, ft = '0, fs = '0, crc = '0;
logic esf = '0, ps = '0, alarm_output_pin = '0, lof = '0, fsy = '0, mfs = '0;
logic ais = '0, fbe = '0, txs = '0, rxs = '0, tick = '0;
logic [2:0] cbit = '0;
logic [5:0] cev = '0;
wire [7:0] rdata;
wire tx_o, bpv_o, lz_o, alarm_o, osc_o, irqn_o, oe_o;
wire [47:0] counts;
int error_cnt = 0, n_compared = 0, cycles = 0;
t1_error_insert_reset_irq_ctrl #(.NCNT(6)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .cs_i(cs), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdat), .rdata_o(rdata),
    .chan_msg_sel_i(msel), .chan_slot_i(cslot), .chan_bit_i(cbit),
    .tx_data_i(tx_i), .ft_slot_i(ft), .fs_slot_i(fs), .crc_slot_i(crc),
    .esf_mode_i(esf), .pulse_slot_i(ps), .tx_data_o(tx_o),
    .bpv_force_o(bpv_o), .line_zero_o(lz_o), .los_i(alarm_output_pin), .lof_i(lof),
    .alarm_pin_o(alarm_o), .osc_ext_sel_o(osc_o), .frame_sync_i(fsy),
    .mframe_sync_i(mfs), .ais_i(ais), .fbit_err_i(fbe), .tx_slip_i(txs),
    .rx_slip_i(rxs), .irq_n_o(irqn_o), .irq_oe_o(oe_o),
    .cnt_event_i(cev), .tick_1s_i(tick), .counts_o(counts)
);
initial forever #50 clk_i = ~clk_i;
// whole run is under a thousand cycles
always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
        error_cnt++;
        conclude();
    end
end
task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #10;
endtask
// one idle edge after each strobe so no signal is set twice at once
task wreg(input logic [7:0] a, input logic [7:0] d);
    cs = 1'b1; wr = 1'b1; addr = a; wdat = d;
    cyc(1);
    cs = 1'b0; wr = 1'b0;
    cyc(1);
endtask
task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
        error_cnt++;
        $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task rchk(input logic [7:0] a, input logic [7:0] exp);
    cs = 1'b1; rd = 1'b1; addr = a;
    cyc(1);
    cs = 1'b0; rd = 1'b0;
    cyc(2);
    chk(rdata, exp);
endtask
task t_regs;
    for (int i = 0; i < 4; i++) rchk(8'h18 + i[7:0], 8'h00);
    rchk(8'h05, 8'h00);
    wreg(8'h18, 8'ha5);
    rchk(8'h18, 8'ha5);
    wreg(8'h1a, 8'h7c);
    rchk(8'h1a, 8'h5c);
    chk(osc_o, 1'b1);
    wreg(8'h1a, 8'h00);
    chk(osc_o, 1'b0);
    wreg(8'h1b, 8'hdb);
    rchk(8'h1b, 8'hdb);
    wreg(8'h1b, 8'h00);
endtask
task t_msg;
    msel = 1'b1; cslot = 1'b1;
    for (int i = 0; i < 8; i++) begin
        cbit = i[2:0];
        cyc(1);
        chk(tx_o, 8'ha5 >> i & 8'h01);
    end
    msel = 1'b0; cslot = 1'b0;
endtask
// rise, hold high, then fall: only the rise injects
task t_inj(input int b);
    int n;
    wreg(8'h19, 8'h00);
    for (int k = 0; k < 3; k++) begin
        wreg(8'h19, k == 2 ? 8'h00 : 8'h01 << b);
        ps = b == 7; crc = b == 6; esf = b == 6;
        ft = b == 5; fs = b == 4; cslot = b == 2;
        n = 0;
        repeat (6) begin
            cyc(1);
            n += b == 7 ? bpv_o : tx_o;
        end
        chk(48'(n), 48'(k == 0));
        {ps, crc, esf, ft, fs, cslot} = 6'h00;
    end
endtask
task t_line;
    tx_i = 1'b1;
    wreg(8'h19, 8'h08);
    chk(lz_o, 1'b1);
    wreg(8'h19, 8'h01);
    chk({lz_o, tx_o}, 2'h1);
    lof = 1'b1;
    cyc(2);
    chk(alarm_o, 1'b0);
    alarm_output_pin = 1'b1;
    cyc(2);
    chk(alarm_o, 1'b1);
    wreg(8'h19, 8'h00);
    alarm_output_pin = 1'b0; tx_i = 1'b0;
    cyc(2);
    chk(alarm_o, 1'b1);
    lof = 1'b0;
endtask
task kick(input int b);
    case (b)
        7: fsy = ~fsy;
        6: mfs = ~mfs;
        4: ais = ~ais;
        3: alarm_output_pin = ~alarm_output_pin;
        2: begin
            {ft, fbe} = 2'h3;
            cyc(2);
            {ft, fbe} = 2'h0;
        end
        1: txs = 1'b1;
        default: rxs = 1'b1;
    endcase
    cyc(1);
    txs = 1'b0; rxs = 1'b0;
    cyc(3);
endtask
task t_irq;
    for (int b = 0; b < 8; b++) if (b != 5) begin
        wreg(8'h1b, ~(8'h01 << b));
        kick(b);
        chk(oe_o, 1'b0);
        wreg(8'h1b, 8'h01 << b);
        kick(b);
        chk({oe_o, irqn_o}, 2'h2);
        wreg(8'h1a, 8'h20);
        chk(oe_o, 1'b0);
    end
    wreg(8'h1b, 8'h02);
    wreg(8'h1a, 8'h40);
    kick(1);
    chk(oe_o, 1'b0);
    wreg(8'h1a, 8'h00);
    chk(oe_o, 1'b0);
    kick(1);
    chk(oe_o, 1'b1);
    wreg(8'h1a, 8'h40);
    chk(oe_o, 1'b0);
    wreg(8'h1a, 8'h20);
endtask
task t_cnt;
    cev = 6'h3f;
    cyc(3);
    cev = 6'h00;
    cyc(2);
    chk(counts, {6{8'h03}});
    wreg(8'h1a, 8'h10);
    cev = 6'h3f;
    cyc(2);
    cev = 6'h00;
    cyc(2);
    chk(counts, 48'h0);
    wreg(8'h1a, 8'h08);
    cev = 6'h3f;
    cyc(2);
    cev = 6'h00;
    cyc(2);
    chk(counts, 48'h0);
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
    chk(counts, {6{8'h02}});
endtask
task t_swrst;
    wreg(8'h18, 8'h5a);
    wreg(8'h1a, 8'h80);
    rchk(8'h1a, 8'h80);
    cyc(6);
    rchk(8'h1a, 8'h00);
    rchk(8'h18, 8'h00);
    chk(counts, 48'h0);
endtask
task conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
initial begin
    cyc(5);
    resetn_i = 1'b1;
    cyc(3);
    t_regs();
    t_msg();
    t_inj(7);
    t_inj(6);
    t_inj(5);
    t_inj(4);
    t_inj(2);
    t_line();
    t_irq();
    t_cnt();
    t_swrst();
    conclude();
end
endmodule // t1_error_insert_reset_irq_ctrl_bench
